/* pim_irq_sink.sv */
// Model of the interrupt controller and cpu event input.
// Assumes level request lines and a one-cycle event pulse.
`timescale 1ns/10ps
module pim_irq_sink (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Requests
	input wire logic [7:0] irq_lines,
	input wire logic cpu_event,
	// Observed
	output logic [7:0] pend,
	output logic [7:0] ev_cnt
);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend <= 8'h00;
			ev_cnt <= 8'h00;
		end else begin
			// Pending per line, never cleared
			pend <= pend | irq_lines;
			ev_cnt <= ev_cnt + {7'h00, cpu_event};
		end
	end
endmodule // pim_irq_sink

/* pim_pin_sync.sv */
// One pin synchroniser with stable level and one-cycle edge pulses.
// Assumes an asynchronous pin and the block clock.
`timescale 1ns/10ps
module pim_pin_sync (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Pin
	input wire logic pin_i,
	// Synchronised level and edges
	output pim_pkg::pim_pin_evt_type evt_o
);

	logic s1_r, s2_r, s3_r, stable_r;
	logic agree;
	logic lvl_nxt;

	// Change only counts once the last two stages agree
	assign agree = (s2_r == s3_r);
	assign lvl_nxt = agree ? s3_r : stable_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			stable_r <= 1'b0;
			evt_o <= '0;
		end else begin
			s1_r <= pin_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			stable_r <= lvl_nxt;
			evt_o.lvl <= lvl_nxt;
			evt_o.rise <= lvl_nxt & ~stable_r;
			evt_o.fall <= ~lvl_nxt & stable_r;
		end
	end

endmodule // pim_pin_sync

/* pim_pkg.sv */
// Constants, field layouts and carrier types of the pin interrupt block.
// Assumes one AHB-Lite slave port and a single always-on block clock.
// Function
// - Eight channels, each one pin, edge- or level-sensitive per mode bit.
// - Each channel drives its own interrupt request line while pattern mode is off.
// - Edge channels request on rising, falling or both edges.
// - Level channels select high or low as the active level.
// - Channel requests wake the part while pattern mode is off; detection needs no core clock.
// - Pattern mode uses up to eight selected pins as expression inputs.
// - Expression is a sum of products over levels and transitions.
// - Each product term raises its own interrupt request when true.
// - Optional one-cycle cpu_event_input pulse on any pattern match.
// - Pattern engine is no wake source; evaluates only while clocks run.
// - Registers answer on the bus without wait states.
package pim_pkg;

	// ******************************
	// Sizes
	// ******************************
	localparam int PIM_CH = 8;
	localparam int PIM_SYNC_STAGES = 3;

	// ******************************
	// Register offsets
	// ******************************
	localparam logic [7:0] PIM_OFS_MODE = 8'h00;
	localparam logic [7:0] PIM_OFS_ENRISE = 8'h04;
	localparam logic [7:0] PIM_OFS_ENFALL = 8'h08;
	localparam logic [7:0] PIM_OFS_RFLAG = 8'h0C;
	localparam logic [7:0] PIM_OFS_FFLAG = 8'h10;
	localparam logic [7:0] PIM_OFS_CHREQ = 8'h14;
	localparam logic [7:0] PIM_OFS_PMCTRL = 8'h18;
	localparam logic [7:0] PIM_OFS_PMSRC = 8'h1C;
	localparam logic [7:0] PIM_OFS_PMCFG = 8'h20;
	localparam logic [7:0] PIM_OFS_PMEND = 8'h24;
	localparam logic [7:0] PIM_OFS_ISTAT = 8'h28;
	localparam logic [7:0] PIM_OFS_ICLR = 8'h2C;
	localparam logic [7:0] PIM_OFS_IEN = 8'h30;

	// ******************************
	// Field positions
	// ******************************
	localparam int PIM_PMCTRL_SEL = 0;
	localparam int PIM_PMCTRL_EVT = 1;
	localparam int PIM_PMCTRL_MATCH = 24;
	localparam int PIM_ISTAT_MATCH = 8;

	// ******************************
	// Reset values
	// ******************************
	localparam logic [7:0] PIM_RST_BYTE = 8'h00;
	localparam logic [15:0] PIM_RST_HALF = 16'h0000;
	localparam logic [23:0] PIM_RST_CFG = 24'h000000;
	localparam logic [1:0] PIM_RST_CTRL = 2'h0;

	// ******************************
	// Product term slice conditions
	// ******************************
	localparam logic [2:0] PIM_PM_TRUE = 3'h0;
	localparam logic [2:0] PIM_PM_STK_RISE = 3'h1;
	localparam logic [2:0] PIM_PM_STK_FALL = 3'h2;
	localparam logic [2:0] PIM_PM_STK_EDGE = 3'h3;
	localparam logic [2:0] PIM_PM_HIGH = 3'h4;
	localparam logic [2:0] PIM_PM_LOW = 3'h5;
	localparam logic [2:0] PIM_PM_FALSE = 3'h6;
	localparam logic [2:0] PIM_PM_EDGE = 3'h7;

	// ******************************
	// Carriers
	// ******************************
	typedef struct packed {
		logic lvl;
		logic rise;
		logic fall;
	} pim_pin_evt_type;

endpackage

/* pim_pm_term.sv */
// One slice of the pattern match product chain.
// Assumes events already synchronised; clr_i comes from register writes.
`timescale 1ns/10ps
module pim_pm_term (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Selected input and condition
	input pim_pkg::pim_pin_evt_type evt_i,
	input wire logic [2:0] cond_i,
	input wire logic clr_i,
	// Slice result
	output logic term_o
);

	logic stk_rise_r, stk_fall_r;
	logic stk_rise, stk_fall;
	logic [7:0] opts;

	// Current edge counts at once, so sticky terms see it this cycle
	assign stk_rise = stk_rise_r | evt_i.rise;
	assign stk_fall = stk_fall_r | evt_i.fall;
	assign opts = {evt_i.rise | evt_i.fall, 1'b0, ~evt_i.lvl, evt_i.lvl,
		stk_rise | stk_fall, stk_fall, stk_rise, 1'b1};
	assign term_o = opts[cond_i];

	// Set wins over clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stk_rise_r <= 1'b0;
			stk_fall_r <= 1'b0;
		end else begin
			stk_rise_r <= (stk_rise_r & ~clr_i) | evt_i.rise;
			stk_fall_r <= (stk_fall_r & ~clr_i) | evt_i.fall;
		end
	end

endmodule // pim_pm_term

/* pim_props.sv */
// Port checker of the pin interrupt block.
// Assumes binding to pim_top, one clock domain.
`timescale 1ns/10ps
module pim_props (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Pins and requests
	input wire logic [7:0] pin_in,
	input wire logic core_run_i,
	input wire logic [7:0] irq_lines,
	input wire logic irq,
	input wire logic cpu_event,
	input wire logic wake_req
);
	// ****
	// Properties
	// ****
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire logic rd_req = hsel && hready && htrans[1] && !hwrite;
	wire logic acc = hsel && htrans[1];
	// Eight cycles covers synchroniser plus pattern and irq stages
	sequence quiet_s;
		($stable(pin_in) && $stable(core_run_i) && !acc)[*8];
	endsequence
	sequence asleep_s;
		(!core_run_i)[*3];
	endsequence
	ready_always_a: assert property (hreadyout)
		else $error("wait state seen");
	resp_okay_a: assert property (!hresp)
		else $error("error response seen");
	rdata_hold_a: assert property (!rd_req |=> $stable(hrdata))
		else $error("read data moved");
	event_pulse_a: assert property (cpu_event |=> !cpu_event)
		else $error("event pulse too long");
	event_asleep_a: assert property (asleep_s |-> !cpu_event)
		else $error("event while clocks stopped");
	event_match_a: assert property (cpu_event |->
		($past(irq_lines) != 8'h00 || irq_lines != 8'h00) or ##1 (irq_lines != 8'h00))
		else $error("event without match");
	wake_chan_a: assert property (wake_req |-> irq_lines != 8'h00)
		else $error("wake without request");
	lines_quiet_a: assert property (quiet_s |=>
		$stable(irq_lines) && $stable(irq) && $stable(wake_req))
		else $error("request moved without cause");
	irq_cause_a: assert property ($rose(irq) |->
		$past(irq_lines) != 8'h00 || irq_lines != 8'h00 || $past(acc, 3))
		else $error("irq without request");
endmodule // pim_props

bind pim_top pim_props i_pim_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .pin_in, .core_run_i,
	.irq_lines, .irq, .cpu_event, .wake_req);

/* pim_top.sv */
// Pin interrupt and pattern match block with AHB-Lite register port.
// Assumes hclk keeps running while the core clock is stopped and that
// core_run_i is a same-domain level from the power controller.
`timescale 1ns/10ps
module pim_top (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Pins and power state
	input wire logic [7:0] pin_in,
	input wire logic core_run_i,
	// Requests to processor_interrupt_controller and cpu_event_input
	output logic [7:0] irq_lines,
	output logic irq,
	output logic cpu_event,
	output logic wake_req
);

	// ******************************
	// Pin front end
	// ******************************
	pim_pkg::pim_pin_evt_type evt_a [pim_pkg::PIM_CH];
	logic [7:0] lvl_v, rise_v, fall_v;

	genvar gi;
	generate
		for (gi = 0; gi < pim_pkg::PIM_CH; gi++) begin : g_pin
			pim_pin_sync u_sync (
				.hclk(hclk),
				.hresetn(hresetn),
				.pin_i(pin_in[gi]),
				.evt_o(evt_a[gi])
			);
			assign lvl_v[gi] = evt_a[gi].lvl;
			assign rise_v[gi] = evt_a[gi].rise;
			assign fall_v[gi] = evt_a[gi].fall;
		end
	endgenerate

	// ******************************
	// Registers
	// ******************************
	logic [7:0] mode_r, enrise_r, enfall_r, rflag_r, fflag_r, pmend_r;
	logic [1:0] pmctrl_r;
	logic [23:0] pmsrc_r, pmcfg_r;
	logic [15:0] istat_r, ien_r;
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	logic match_d_r;

	// ******************************
	// Bus decode
	// ******************************
	logic acc;
	logic rd_acc;
	logic [7:0] ra;
	logic w_mode, w_enr, w_enf, w_rfl, w_ffl;
	logic w_ctrl, w_src, w_cfg, w_end, w_iclr, w_ien;
	logic [31:0] rd_mux;
	logic r_mode, r_enr, r_enf, r_rfl, r_ffl, r_chreq;
	logic r_ctrl, r_src, r_cfg, r_end, r_istat, r_ien;

	assign acc = hsel & hready & htrans[1];
	assign rd_acc = acc & ~hwrite;
	assign ra = haddr[7:0];
	assign w_mode = wr_pend_r && (wr_addr_r == pim_pkg::PIM_OFS_MODE);
	assign w_enr = wr_pend_r && (wr_addr_r == pim_pkg::PIM_OFS_ENRISE);
	assign w_enf = wr_pend_r && (wr_addr_r == pim_pkg::PIM_OFS_ENFALL);
	assign w_rfl = wr_pend_r && (wr_addr_r == pim_pkg::PIM_OFS_RFLAG);
	assign w_ffl = wr_pend_r && (wr_addr_r == pim_pkg::PIM_OFS_FFLAG);
	assign w_ctrl = wr_pend_r && (wr_addr_r == pim_pkg::PIM_OFS_PMCTRL);
	assign w_src = wr_pend_r && (wr_addr_r == pim_pkg::PIM_OFS_PMSRC);
	assign w_cfg = wr_pend_r && (wr_addr_r == pim_pkg::PIM_OFS_PMCFG);
	assign w_end = wr_pend_r && (wr_addr_r == pim_pkg::PIM_OFS_PMEND);
	assign w_iclr = wr_pend_r && (wr_addr_r == pim_pkg::PIM_OFS_ICLR);
	assign w_ien = wr_pend_r && (wr_addr_r == pim_pkg::PIM_OFS_IEN);
	// Read selects decode the live address phase, not the latched one
	assign r_mode = (ra == pim_pkg::PIM_OFS_MODE);
	assign r_enr = (ra == pim_pkg::PIM_OFS_ENRISE);
	assign r_enf = (ra == pim_pkg::PIM_OFS_ENFALL);
	assign r_rfl = (ra == pim_pkg::PIM_OFS_RFLAG);
	assign r_ffl = (ra == pim_pkg::PIM_OFS_FFLAG);
	assign r_chreq = (ra == pim_pkg::PIM_OFS_CHREQ);
	assign r_ctrl = (ra == pim_pkg::PIM_OFS_PMCTRL);
	assign r_src = (ra == pim_pkg::PIM_OFS_PMSRC);
	assign r_cfg = (ra == pim_pkg::PIM_OFS_PMCFG);
	assign r_end = (ra == pim_pkg::PIM_OFS_PMEND);
	assign r_istat = (ra == pim_pkg::PIM_OFS_ISTAT);
	assign r_ien = (ra == pim_pkg::PIM_OFS_IEN);

	// ******************************
	// Pin interrupt channels
	// ******************************
	logic [7:0] edge_mode, lvl_act, ch_req;
	logic [7:0] rflag_nxt, fflag_nxt;

	assign edge_mode = ~mode_r;
	// Enable bit per edge direction gives rising, falling or both
	assign rflag_nxt = (rflag_r & ~(w_rfl ? hwdata[7:0] : 8'h00))
		| (rise_v & enrise_r & edge_mode);
	assign fflag_nxt = (fflag_r & ~(w_ffl ? hwdata[7:0] : 8'h00))
		| (fall_v & enfall_r & edge_mode);
	// In level mode enfall picks the active level, enrise enables
	assign lvl_act = ~(lvl_v ^ enfall_r);
	assign ch_req = (mode_r & enrise_r & lvl_act)
		| (edge_mode & (rflag_r | fflag_r));

	// ******************************
	// Pattern match engine
	// ******************************
	logic [7:0] term_v, prod_v, match_v;
	logic pm_clr;
	logic pm_sel;
	logic any_match;

	// Reprogramming restarts sticky edge memory
	assign pm_clr = w_src | w_cfg | w_end | w_ctrl;
	assign pm_sel = pmctrl_r[pim_pkg::PIM_PMCTRL_SEL];

	generate
		for (gi = 0; gi < pim_pkg::PIM_CH; gi++) begin : g_pm
			pim_pm_term u_term (
				.hclk(hclk),
				.hresetn(hresetn),
				.evt_i(evt_a[pmsrc_r[3*gi +: 3]]),
				.cond_i(pmcfg_r[3*gi +: 3]),
				.clr_i(pm_clr),
				.term_o(term_v[gi])
			);
			if (gi == 0) begin : g_first
				assign prod_v[gi] = term_v[gi];
			end else begin : g_next
				// An endpoint bit closes the product before this slice
				assign prod_v[gi] = term_v[gi]
					& (pmend_r[gi-1] | prod_v[gi-1]);
			end
		end
	endgenerate

	// Evaluated only while clocks run; never a wake source
	assign match_v = prod_v & pmend_r & {8{core_run_i & pm_sel}};
	assign any_match = |match_v;

	// ******************************
	// Interrupt status
	// ******************************
	logic [15:0] ev_v, istat_nxt;
	logic [7:0] line_nxt;

	assign ev_v = {match_v, ch_req & {8{~pm_sel}}};
	// Events set over a same-cycle clear
	assign istat_nxt = (istat_r & ~(w_iclr ? hwdata[15:0] : 16'h0000)) | ev_v;
	assign line_nxt = pm_sel ? match_v : ch_req;

	// ******************************
	// Read mux
	// ******************************
	assign rd_mux =
		r_mode ? {24'h000000, mode_r} :
		r_enr ? {24'h000000, enrise_r} :
		r_enf ? {24'h000000, enfall_r} :
		r_rfl ? {24'h000000, rflag_r} :
		r_ffl ? {24'h000000, fflag_r} :
		r_chreq ? {24'h000000, ch_req} :
		r_ctrl ? {match_v, 22'h000000, pmctrl_r} :
		r_src ? {8'h00, pmsrc_r} :
		r_cfg ? {8'h00, pmcfg_r} :
		r_end ? {24'h000000, pmend_r} :
		r_istat ? {16'h0000, istat_r} :
		r_ien ? {16'h0000, ien_r} :
		32'h00000000;

	// ******************************
	// Bus sequencing
	// ******************************
	// Read data is latched in the address phase so no wait state is needed
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= pim_pkg::PIM_RST_BYTE;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend_r <= acc & hwrite;
			wr_addr_r <= ra;
			hrdata <= rd_acc ? rd_mux : hrdata;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// ******************************
	// Configuration registers
	// ******************************
	// One short process per register keeps each write strobe local
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_r <= pim_pkg::PIM_RST_BYTE;
		end else begin
			mode_r <= w_mode ? hwdata[7:0] : mode_r;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			enrise_r <= pim_pkg::PIM_RST_BYTE;
		end else begin
			enrise_r <= w_enr ? hwdata[7:0] : enrise_r;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			enfall_r <= pim_pkg::PIM_RST_BYTE;
		end else begin
			enfall_r <= w_enf ? hwdata[7:0] : enfall_r;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pmctrl_r <= pim_pkg::PIM_RST_CTRL;
		end else begin
			pmctrl_r <= w_ctrl ? hwdata[1:0] : pmctrl_r;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pmsrc_r <= pim_pkg::PIM_RST_CFG;
		end else begin
			pmsrc_r <= w_src ? hwdata[23:0] : pmsrc_r;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pmcfg_r <= pim_pkg::PIM_RST_CFG;
		end else begin
			pmcfg_r <= w_cfg ? hwdata[23:0] : pmcfg_r;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pmend_r <= pim_pkg::PIM_RST_BYTE;
		end else begin
			pmend_r <= w_end ? hwdata[7:0] : pmend_r;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ien_r <= pim_pkg::PIM_RST_HALF;
		end else begin
			ien_r <= w_ien ? hwdata[15:0] : ien_r;
		end
	end

	// ******************************
	// Flags and status
	// ******************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rflag_r <= pim_pkg::PIM_RST_BYTE;
			fflag_r <= pim_pkg::PIM_RST_BYTE;
			istat_r <= pim_pkg::PIM_RST_HALF;
			match_d_r <= 1'b0;
		end else begin
			rflag_r <= rflag_nxt;
			fflag_r <= fflag_nxt;
			istat_r <= istat_nxt;
			match_d_r <= any_match;
		end
	end

	// ******************************
	// Outputs
	// ******************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_lines <= pim_pkg::PIM_RST_BYTE;
			irq <= 1'b0;
			cpu_event <= 1'b0;
			wake_req <= 1'b0;
		end else begin
			irq_lines <= line_nxt;
			irq <= |(istat_r & ien_r);
			// One pulse per new match, not a level
			cpu_event <= pmctrl_r[pim_pkg::PIM_PMCTRL_EVT]
				& any_match & ~match_d_r;
			// Pattern matches deliberately excluded from wake
			wake_req <= ~pm_sel & |ch_req;
		end
	end

endmodule // pim_top

/* pim_top_tb.sv */
// Self-checking bench of the pin interrupt block.
// Assumes pim_top, pim_irq_sink and the bound checker.
`timescale 1ns/10ps
module pim_top_tb;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [7:0] pin_in = 8'h00;
	logic core_run_i = 1'b1;
	logic [31:0] hrdata;
	logic hreadyout, hresp, irq, cpu_event, wake_req;
	logic [7:0] irq_lines, sink_pend, sink_ev;
	int error_cnt = 0;
	int checked = 0;
	int tmo = 0;
	pim_top i_pim_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pin_in,
		.core_run_i, .irq_lines, .irq, .cpu_event, .wake_req);
	pim_irq_sink i_pim_irq_sink (.hclk, .hresetn, .irq_lines, .cpu_event,
		.pend(sink_pend), .ev_cnt(sink_ev));
	always #50 hclk = ~hclk;
	// ****
	// Shared tasks
	// ****
	task automatic test_done;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	always @(posedge hclk) begin
		tmo++;
		if (tmo == 5000) begin
			error_cnt++;
			test_done();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
			error_cnt++;
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h000000, a};
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(r, e);
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_regs;
		rchk(pim_pkg::PIM_OFS_MODE, 32'h0);
		rchk(8'h40, 32'h0);
		wr(pim_pkg::PIM_OFS_ISTAT, 32'hFF);
		rchk(pim_pkg::PIM_OFS_ISTAT, 32'h0);
		wr(pim_pkg::PIM_OFS_MODE, 32'hA5);
		rchk(pim_pkg::PIM_OFS_MODE, 32'hA5);
		wr(pim_pkg::PIM_OFS_MODE, 32'h0);
	endtask
	task automatic t_edge;
		wr(pim_pkg::PIM_OFS_ENRISE, 32'h05);
		wr(pim_pkg::PIM_OFS_ENFALL, 32'h06);
		pin_in <= 8'h07;
		cyc(10);
		pin_in <= 8'h00;
		cyc(10);
		rchk(pim_pkg::PIM_OFS_RFLAG, 32'h05);
		rchk(pim_pkg::PIM_OFS_FFLAG, 32'h06);
		rchk(pim_pkg::PIM_OFS_CHREQ, 32'h07);
		chk(32'(irq_lines), 32'h07);
		chk(32'(sink_pend), 32'h07);
		chk(32'(irq), 32'h0);
		wr(pim_pkg::PIM_OFS_IEN, 32'hFF);
		cyc(3);
		chk(32'(irq), 32'h1);
		wr(pim_pkg::PIM_OFS_RFLAG, 32'h05);
		wr(pim_pkg::PIM_OFS_FFLAG, 32'h06);
		wr(pim_pkg::PIM_OFS_ICLR, 32'hFF);
		cyc(3);
		chk(32'(irq_lines), 32'h0);
		chk(32'(irq), 32'h0);
	endtask
	task automatic t_level;
		pin_in <= 8'h20;
		core_run_i <= 1'b0;
		wr(pim_pkg::PIM_OFS_MODE, 32'h30);
		wr(pim_pkg::PIM_OFS_ENFALL, 32'h10);
		wr(pim_pkg::PIM_OFS_ENRISE, 32'h30);
		cyc(8);
		chk(32'(irq_lines), 32'h0);
		pin_in <= 8'h10;
		cyc(30);
		chk(32'(irq_lines), 32'h30);
		chk(32'(wake_req), 32'h1);
		pin_in <= 8'h20;
		cyc(8);
		chk(32'(irq_lines), 32'h0);
		core_run_i <= 1'b1;
		wr(pim_pkg::PIM_OFS_ENRISE, 32'h0);
		wr(pim_pkg::PIM_OFS_MODE, 32'h0);
		wr(pim_pkg::PIM_OFS_ICLR, 32'hFF);
	endtask
	task automatic t_pattern;
		logic [7:0] e0;
		pin_in <= 8'h40;
		wr(pim_pkg::PIM_OFS_PMSRC, 32'h3E);
		wr(pim_pkg::PIM_OFS_PMEND, 32'h01);
		wr(pim_pkg::PIM_OFS_PMCTRL, 32'h03);
		for (int c = 0; c < 8; c++) begin
			wr(pim_pkg::PIM_OFS_PMCFG, 32'(c));
			cyc(8);
			chk(32'(irq_lines[0]), 32'(c == 0 || c == 4));
		end
		wr(pim_pkg::PIM_OFS_PMCFG, 32'h1);
		pin_in <= 8'h00;
		cyc(8);
		pin_in <= 8'h40;
		cyc(8);
		chk(32'(irq_lines[0]), 32'h1);
		wr(pim_pkg::PIM_OFS_PMCFG, 32'h24);
		wr(pim_pkg::PIM_OFS_PMEND, 32'h02);
		cyc(8);
		chk(32'(irq_lines), 32'h0);
		e0 = sink_ev;
		pin_in <= 8'hC0;
		cyc(8);
		chk(32'(irq_lines), 32'h02);
		chk(32'(sink_ev), 32'(e0 + 8'h01));
		rchk(pim_pkg::PIM_OFS_PMCTRL, 32'h02000003);
		core_run_i <= 1'b0;
		cyc(8);
		chk(32'(irq_lines), 32'h0);
		chk(32'(wake_req), 32'h0);
		core_run_i <= 1'b1;
		cyc(8);
		chk(32'(sink_ev), 32'(e0 + 8'h02));
	endtask
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_edge();
		t_level();
		t_pattern();
		test_done();
	end
endmodule // pim_top_tb
